// ---- pcs_regs.sv ----
// Purpose: Phase compensation registers and power sign status over Wishbone.
// Assumes: Power results arrive on clk_i with a one-cycle valid strobe.
// Notes: Each sign change raises a sticky interrupt bit, write one to clear.
//
// Operation
// - Values 384..511 act like 256..383.
// - Values 576..1023 act like 256..383, repeating every 128.
// - Upper six compensation bits reserved, reset zero.
// - Bits 0..2 show selected phase active sign.
// - Bits 4..6 show selected phase reactive sign.
// - No reactive measurement: reactive signs read zero.
// - Bits 3, 7, 8 show pulse sum signs.
// - Sum uses datapath phase include and quantity.
// - Status bits 15..9 always read zero.
// - Quantity codes choose power; 101..111 suppress output.
`timescale 1ns/1ps
`default_nettype none
module pcs_regs
  import pcs_pkg::*;
#(
  parameter bit HAS_REACTIVE = 1'b1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [17:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic result_valid_i,
  input wire logic [3*POWER_W-1:0] total_active_i,
  input wire logic [3*POWER_W-1:0] total_reactive_i,
  input wire logic [3*POWER_W-1:0] apparent_i,
  input wire logic [3*POWER_W-1:0] fund_active_i,
  input wire logic [3*POWER_W-1:0] fund_reactive_i,
  output logic [COMP_W-1:0] phase_a_comp_eff_o,
  output logic [COMP_W-1:0] phase_b_comp_eff_o,
  output logic [COMP_W-1:0] phase_c_comp_eff_o,
  output logic pulse_out_one_en_o,
  output logic pulse_out_two_en_o,
  output logic pulse_out_three_en_o,
  output logic irq_o
);

  // Folds the out-of-range codes onto the range that the filter really uses.
  function automatic logic [COMP_W-1:0] comp_alias(
    input logic [COMP_W-1:0] v
  );
    logic [COMP_W-1:0] r;
    r = v;
    if (v >= COMP_ALIAS2_LO) begin
      r = COMP_ALIAS_BASE + ((v - COMP_ALIAS2_LO) & (COMP_ALIAS_SHIFT - 10'h001));
    end else if (v >= COMP_ALIAS1_LO && v <= COMP_ALIAS1_HI) begin
      r = v - COMP_ALIAS_SHIFT;
    end
    return r;
  endfunction

  function automatic logic signed [POWER_W-1:0] lane(
    input logic [3*POWER_W-1:0] bus,
    input int ph
  );
    return bus[ph*POWER_W +: POWER_W];
  endfunction

  // One phase's contribution to a pulse datapath; zero when not included.
  function automatic logic signed [SUM_W-1:0] term(
    input logic [2:0] qsel,
    input logic incl,
    input int ph,
    input logic [3*POWER_W-1:0] ta,
    input logic [3*POWER_W-1:0] tr,
    input logic [3*POWER_W-1:0] ap,
    input logic [3*POWER_W-1:0] fa,
    input logic [3*POWER_W-1:0] fr
  );
    logic signed [POWER_W-1:0] p;
    p = '0;
    if (incl) begin
      unique case (qsel)
        PCS_Q_TOTAL_ACTIVE: p = lane(ta, ph);
        PCS_Q_TOTAL_REACTIVE: p = lane(tr, ph);
        PCS_Q_APPARENT: p = lane(ap, ph);
        PCS_Q_FUND_ACTIVE: p = lane(fa, ph);
        PCS_Q_FUND_REACTIVE: p = lane(fr, ph);
        default: p = '0;
      endcase
    end
    return SUM_W'(p);
  endfunction

  function automatic logic sum_neg(
    input logic [2:0] qsel,
    input logic [2:0] incl,
    input logic [3*POWER_W-1:0] ta,
    input logic [3*POWER_W-1:0] tr,
    input logic [3*POWER_W-1:0] ap,
    input logic [3*POWER_W-1:0] fa,
    input logic [3*POWER_W-1:0] fr
  );
    logic signed [SUM_W-1:0] s;
    s = term(qsel, incl[0], 0, ta, tr, ap, fa, fr)
      + term(qsel, incl[1], 1, ta, tr, ap, fa, fr)
      + term(qsel, incl[2], 2, ta, tr, ap, fa, fr);
    return s[SUM_W-1];
  endfunction

  function automatic logic quantity_ok(input logic [2:0] qsel);
    return qsel <= 3'(PCS_Q_FUND_REACTIVE);
  endfunction

  logic [REG_W-1:0] phase_a_delay_comp;
  logic [REG_W-1:0] phase_b_delay_comp;
  logic [REG_W-1:0] phase_c_delay_comp;
  logic [REG_W-1:0] sign_ctrl;
  logic [8:0] pulse_include;
  logic [8:0] pulse_qsel;
  logic [8:0] power_sign;
  logic [8:0] irq_status;
  logic [8:0] irq_mask;
  logic ack;
  logic [31:0] rdata;

  // Bus decode.
  wire logic [IDX_W-1:0] idx = adr_i[17:2];
  wire logic req = cyc_i & stb_i & ~ack;
  wire logic wr = req & we_i;
  wire logic lo_lane = sel_i[0];
  wire logic hi_lane = sel_i[1];
  wire logic top_lane = sel_i[2];
  wire logic hit_a = idx == IDX_PHASE_A_COMP;
  wire logic hit_b = idx == IDX_PHASE_B_COMP;
  wire logic hit_c = idx == IDX_PHASE_C_COMP;
  wire logic hit_sign = idx == IDX_POWER_SIGN;
  wire logic hit_ctrl = idx == IDX_SIGN_CTRL;
  wire logic hit_cfg = idx == IDX_PULSE_CFG;
  wire logic hit_ists = idx == IDX_IRQ_STATUS;
  wire logic hit_imsk = idx == IDX_IRQ_MASK;

  // Per-register write strobes; each register block sees only its own.
  wire logic wr_a = wr & hit_a;
  wire logic wr_b = wr & hit_b;
  wire logic wr_c = wr & hit_c;
  wire logic wr_ctrl = wr & hit_ctrl;
  wire logic wr_cfg = wr & hit_cfg;
  wire logic wr_ists = wr & hit_ists;
  wire logic wr_imsk = wr & hit_imsk;

  // Merge a write into a 16-bit register honouring the two low byte lanes.
  function automatic logic [REG_W-1:0] merge16(
    input logic [REG_W-1:0] old,
    input logic [31:0] d,
    input logic [3:0] sel
  );
    return {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
  endfunction

  wire logic [REG_W-1:0] cfg_now = {
    pulse_qsel[6:0], pulse_include
  };
  wire logic [REG_W-1:0] cfg_new = merge16(cfg_now, dat_i, sel_i);
  wire logic [8:0] qsel_new = {
    top_lane ? dat_i[17:16] : pulse_qsel[8:7], cfg_new[15:9]
  };
  wire logic [8:0] w1c = wr_ists ?
    {hi_lane & dat_i[8], lo_lane ? dat_i[7:0] : 8'h00} : 9'h000;

  // Only the value field of a compensation register is kept; the
  // reserved top bits are dropped at the write so they always read zero.
  wire logic [REG_W-1:0] next_phase_a_delay_comp =
    merge16(phase_a_delay_comp, dat_i, sel_i) & COMP_FIELD_MASK;
  wire logic [REG_W-1:0] next_phase_b_delay_comp =
    merge16(phase_b_delay_comp, dat_i, sel_i) & COMP_FIELD_MASK;
  wire logic [REG_W-1:0] next_phase_c_delay_comp =
    merge16(phase_c_delay_comp, dat_i, sel_i) & COMP_FIELD_MASK;
  wire logic [REG_W-1:0] next_sign_ctrl =
    merge16(sign_ctrl, dat_i, sel_i) & SIGN_CTRL_MASK;
  wire logic [8:0] next_irq_mask = {
    hi_lane ? dat_i[8] : irq_mask[8], lo_lane ? dat_i[7:0] : irq_mask[7:0]
  };

  // Sign sources.
  wire logic act_fund = sign_ctrl[ACTIVE_SRC_BIT];
  wire logic react_fund = sign_ctrl[REACTIVE_SRC_BIT];
  wire logic [2:0] act_neg;
  wire logic [2:0] react_neg;
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_phase
      wire logic signed [POWER_W-1:0] act_p = act_fund ?
        lane(fund_active_i, g) : lane(total_active_i, g);
      wire logic signed [POWER_W-1:0] react_p = react_fund ?
        lane(fund_reactive_i, g) : lane(total_reactive_i, g);
      assign act_neg[g] = act_p[POWER_W-1];
      assign react_neg[g] = HAS_REACTIVE & react_p[POWER_W-1];
    end
  endgenerate

  wire logic sum1 = sum_neg(pulse_qsel[2:0], pulse_include[2:0],
    total_active_i, total_reactive_i, apparent_i, fund_active_i,
    fund_reactive_i);
  wire logic sum2 = sum_neg(pulse_qsel[5:3], pulse_include[5:3],
    total_active_i, total_reactive_i, apparent_i, fund_active_i,
    fund_reactive_i);
  wire logic sum3 = sum_neg(pulse_qsel[8:6], pulse_include[8:6],
    total_active_i, total_reactive_i, apparent_i, fund_active_i,
    fund_reactive_i);

  // Status layout: 8 sum3, 7 sum2, 6..4 reactive, 3 sum1, 2..0 active.
  wire logic [8:0] next_power_sign = {sum3, sum2, react_neg, sum1, act_neg};
  wire logic [8:0] sign_flip = result_valid_i ?
    (next_power_sign ^ power_sign) : 9'h000;

  // Read views, each zero-extended to the bus width.
  wire logic [31:0] view_a = {16'h0000, 6'h00, phase_a_delay_comp[9:0]};
  wire logic [31:0] view_b = {16'h0000, 6'h00, phase_b_delay_comp[9:0]};
  wire logic [31:0] view_c = {16'h0000, 6'h00, phase_c_delay_comp[9:0]};
  wire logic [31:0] view_sign = {16'h0000, 7'h00, power_sign};
  wire logic [31:0] view_ctrl = {16'h0000, sign_ctrl};
  wire logic [31:0] view_cfg = {14'h0000, pulse_qsel, pulse_include};
  wire logic [31:0] view_ists = {23'h000000, irq_status};
  wire logic [31:0] view_imsk = {23'h000000, irq_mask};

  wire logic [31:0] read_mux =
    hit_a ? view_a :
    hit_b ? view_b :
    hit_c ? view_c :
    hit_sign ? view_sign :
    hit_ctrl ? view_ctrl :
    hit_cfg ? view_cfg :
    hit_ists ? view_ists :
    hit_imsk ? view_imsk : 32'h00000000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_a_delay_comp <= RST_PHASE_COMP;
    end else if (wr_a) begin
      phase_a_delay_comp <= next_phase_a_delay_comp;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_b_delay_comp <= RST_PHASE_COMP;
    end else if (wr_b) begin
      phase_b_delay_comp <= next_phase_b_delay_comp;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_c_delay_comp <= RST_PHASE_COMP;
    end else if (wr_c) begin
      phase_c_delay_comp <= next_phase_c_delay_comp;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sign_ctrl <= RST_SIGN_CTRL;
    end else if (wr_ctrl) begin
      sign_ctrl <= next_sign_ctrl;
    end
  end

  // Include bits and quantity codes share one word, so one write moves both.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pulse_include <= RST_PHASE_INCLUDE;
      pulse_qsel <= RST_QUANTITY_SEL;
    end else if (wr_cfg) begin
      pulse_include <= cfg_new[8:0];
      pulse_qsel <= qsel_new;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask <= RST_IRQ;
    end else if (wr_imsk) begin
      irq_mask <= next_irq_mask;
    end
  end

  // Status follows the computed results only; host writes never reach it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      power_sign <= RST_POWER_SIGN;
    end else if (result_valid_i) begin
      power_sign <= next_power_sign;
    end
  end

  // A flip in the same cycle as a write-one clear keeps the bit set.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_status <= RST_IRQ;
    end else begin
      irq_status <= (irq_status & ~w1c) | sign_flip;
    end
  end

  // Ack is a registered pulse and masks the request while it stands, so
  // a master that holds its strobe into the ack cycle is not taken twice.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack <= 1'b0;
      rdata <= 32'h00000000;
    end else begin
      ack <= req;
      rdata <= (req && !we_i) ? read_mux : 32'h00000000;
    end
  end

  // Effective codes seen by the delay filters. They are registered so a
  // filter never sees a code while a write to the register is landing.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_a_comp_eff_o <= '0;
      phase_b_comp_eff_o <= '0;
      phase_c_comp_eff_o <= '0;
      pulse_out_one_en_o <= 1'b0;
      pulse_out_two_en_o <= 1'b0;
      pulse_out_three_en_o <= 1'b0;
    end else begin
      phase_a_comp_eff_o <= comp_alias(phase_a_delay_comp[9:0]);
      phase_b_comp_eff_o <= comp_alias(phase_b_delay_comp[9:0]);
      phase_c_comp_eff_o <= comp_alias(phase_c_delay_comp[9:0]);
      pulse_out_one_en_o <= quantity_ok(pulse_qsel[2:0]);
      pulse_out_two_en_o <= quantity_ok(pulse_qsel[5:3]);
      pulse_out_three_en_o <= quantity_ok(pulse_qsel[8:6]);
    end
  end

  assign ack_o = ack;
  assign dat_o = rdata;
  assign irq_o = |(irq_status & irq_mask);

endmodule
`default_nettype wire

// ---- pcs_pkg.sv ----
// Purpose: Shared constants for the phase compensation and power sign block.
// Assumes: Classic Wishbone with 32-bit data, one word per register index.
// Notes: Register byte address is four times the register index.
package pcs_pkg;

  localparam int POWER_W = 24;
  localparam int SUM_W = POWER_W + 2;
  localparam int COMP_W = 10;
  localparam int REG_W = 16;
  localparam int IDX_W = 16;

  // Register indices; the bus byte address is index * 4.
  localparam logic [IDX_W-1:0] IDX_PHASE_A_COMP = 16'he614;
  localparam logic [IDX_W-1:0] IDX_PHASE_B_COMP = 16'he615;
  localparam logic [IDX_W-1:0] IDX_PHASE_C_COMP = 16'he616;
  localparam logic [IDX_W-1:0] IDX_POWER_SIGN = 16'he617;
  localparam logic [IDX_W-1:0] IDX_SIGN_CTRL = 16'he6f0;
  localparam logic [IDX_W-1:0] IDX_PULSE_CFG = 16'he6f1;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 16'he6f2;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 16'he6f3;

  // Reset values.
  localparam logic [REG_W-1:0] RST_PHASE_COMP = 16'h0000;
  localparam logic [REG_W-1:0] RST_SIGN_CTRL = 16'h0000;
  localparam logic [8:0] RST_PHASE_INCLUDE = 9'h1ff;
  localparam logic [8:0] RST_QUANTITY_SEL = 9'h088;
  localparam logic [8:0] RST_IRQ = 9'h000;
  localparam logic [8:0] RST_POWER_SIGN = 9'h000;

  // Field positions.
  localparam int ACTIVE_SRC_BIT = 0;
  localparam int REACTIVE_SRC_BIT = 1;
  localparam int PULSE_INCLUDE_LSB = 0;
  localparam int PULSE_QSEL_LSB = 9;
  localparam logic [REG_W-1:0] COMP_FIELD_MASK = 16'h03ff;
  localparam logic [REG_W-1:0] SIGN_CTRL_MASK = 16'h0003;

  // Phase compensation alias boundaries.
  localparam logic [COMP_W-1:0] COMP_ALIAS1_LO = 10'h180;
  localparam logic [COMP_W-1:0] COMP_ALIAS1_HI = 10'h1ff;
  localparam logic [COMP_W-1:0] COMP_ALIAS2_LO = 10'h240;
  localparam logic [COMP_W-1:0] COMP_ALIAS_SHIFT = 10'h080;
  localparam logic [COMP_W-1:0] COMP_ALIAS_BASE = 10'h100;

  typedef enum logic [2:0] {
    PCS_Q_TOTAL_ACTIVE,
    PCS_Q_TOTAL_REACTIVE,
    PCS_Q_APPARENT,
    PCS_Q_FUND_ACTIVE,
    PCS_Q_FUND_REACTIVE
  } pcs_quantity_t;

endpackage

// ---- pcs_regs_sva.sv ----
// Purpose: Port-level assertions for the phase compensation register block.
// Assumes: One clock, synchronous active-high reset.
// Notes: Bound onto every pcs_regs instance.
`timescale 1ns/1ps
`default_nettype none
module pcs_regs_sva
  import pcs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [17:0] adr_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic result_valid_i,
  input wire logic [COMP_W-1:0] phase_a_comp_eff_o,
  input wire logic [COMP_W-1:0] phase_b_comp_eff_o,
  input wire logic [COMP_W-1:0] phase_c_comp_eff_o,
  input wire logic irq_o
);
  default clocking
    @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence bus_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence rd_ack(logic [15:0] idx);
    $past(cyc_i && stb_i && !we_i && adr_i[17:2] == idx) ##0 ack_o;
  endsequence
  // Effective codes never land in the aliased bands.
  property eff_ok(logic [9:0] e);
    e < 10'h180 || (e >= 10'h200 && e <= 10'h23f);
  endproperty
  ack_timing_a: assert property (bus_req |=> ack_o)
    else $error("ack missing after request");
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  comp_reserved_a: assert property (rd_ack(IDX_PHASE_A_COMP) |-> dat_o[31:10] == '0)
    else $error("compensation reserved bits nonzero");
  sign_reserved_a: assert property (rd_ack(IDX_POWER_SIGN) |-> dat_o[31:9] == '0)
    else $error("sign reserved bits nonzero");
  eff_a_range_a: assert property (eff_ok(phase_a_comp_eff_o))
    else $error("phase a effective code out of band");
  eff_b_range_a: assert property (eff_ok(phase_b_comp_eff_o))
    else $error("phase b effective code out of band");
  eff_c_range_a: assert property (eff_ok(phase_c_comp_eff_o))
    else $error("phase c effective code out of band");
  eff_cause_a: assert property (!$stable(phase_a_comp_eff_o) |->
    $past(cyc_i && stb_i && we_i, 1) || $past(cyc_i && stb_i && we_i, 2))
    else $error("effective code changed without a write");
  irq_cause_a: assert property ($rose(irq_o) |->
    $past(result_valid_i || (cyc_i && stb_i && we_i)))
    else $error("interrupt rose without cause");
endmodule
bind pcs_regs pcs_regs_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o),
  .result_valid_i(result_valid_i), .phase_a_comp_eff_o(phase_a_comp_eff_o),
  .phase_b_comp_eff_o(phase_b_comp_eff_o),
  .phase_c_comp_eff_o(phase_c_comp_eff_o), .irq_o(irq_o));
`default_nettype wire

// ---- pcs_regs_tb.sv ----
// Purpose: Self-checking bench for the phase compensation register block.
// Assumes: Wishbone classic master driven on rising edges.
// Notes: Random powers and settings come from a fixed xorshift seed.
`timescale 1ns/1ps
`default_nettype none
module pcs_regs_tb
  import pcs_pkg::*;
();
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, rv = 0;
  logic [17:0] adr_i = '0;
  logic [31:0] dat_i = '0, dat_o, dat_o2, q, q2, r, d, seed = 32'h32;
  logic [71:0] pw [5] = '{default: '0};
  logic [95:0] w;
  logic [9:0] eff [3];
  logic [2:0] pen;
  logic ack_o, irq_o;
  logic [15:0] exp_s, prev_s;
  logic [8:0] ist, msk;
  logic [1:0] sc;
  logic [17:0] cfg;
  // Legal leading and lagging codes, then both ends of the aliased bands.
  logic [9:0] corner [8] = '{10'h000, 10'h17f,
    10'h200, 10'h23f,
    10'h180, 10'h1ff, 10'h240, 10'h3ff};
  int n_fail = 0, comparisons = 0;
  pcs_regs dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(4'hf), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .result_valid_i(rv), .total_active_i(pw[0]),
    .total_reactive_i(pw[1]), .apparent_i(pw[2]), .fund_active_i(pw[3]),
    .fund_reactive_i(pw[4]), .phase_a_comp_eff_o(eff[0]),
    .phase_b_comp_eff_o(eff[1]), .phase_c_comp_eff_o(eff[2]),
    .pulse_out_one_en_o(pen[0]), .pulse_out_two_en_o(pen[1]),
    .pulse_out_three_en_o(pen[2]), .irq_o(irq_o));
  // Same traffic into a part without reactive measurement.
  pcs_regs #(.HAS_REACTIVE(1'b0)) dut2 (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(4'hf),
    .dat_i(dat_i), .dat_o(dat_o2), .ack_o(), .result_valid_i(rv),
    .total_active_i(pw[0]), .total_reactive_i(pw[1]), .apparent_i(pw[2]),
    .fund_active_i(pw[3]), .fund_reactive_i(pw[4]),
    .phase_a_comp_eff_o(), .phase_b_comp_eff_o(), .phase_c_comp_eff_o(),
    .pulse_out_one_en_o(), .pulse_out_two_en_o(), .pulse_out_three_en_o(),
    .irq_o());
  always #10 clk_i = ~clk_i;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [9:0] alias_of(logic [9:0] v);
    if (v < 10'h180 || (v >= 10'h200 && v < 10'h240)) return v;
    if (v < 10'h200) return v - 10'h080;
    return 10'h100 + ((v - 10'h240) & 10'h07f);
  endfunction
  // Quantity codes index the power array directly: 0 total active .. 4.
  function automatic logic [15:0] exp_sign(logic [1:0] s, logic [17:0] c);
    logic [15:0] e;
    int sum;
    logic [2:0] qs;
    e = '0;
    for (int p = 0; p < 3; p++) begin
      e[p] = pw[s[0] ? 3 : 0][24*p+23];
      e[4+p] = pw[s[1] ? 4 : 1][24*p+23];
    end
    for (int k = 0; k < 3; k++) begin
      qs = c[9+3*k +: 3];
      sum = 0;
      for (int p = 0; p < 3; p++) begin
        if (qs < 3'h5 && c[3*k+p]) sum += $signed(pw[qs][24*p +: 24]);
      end
      e[k == 0 ? 3 : (k == 1 ? 7 : 8)] = sum < 0;
    end
    return e;
  endfunction
  task automatic close_out();
    $display("Counts: %0d mismatches, %0d comparisons", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic wr, input logic [15:0] idx,
    input logic [31:0] wd, output logic [31:0] rd);
    int n;
    @(posedge clk_i);
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= wr;
    adr_i <= {idx, 2'b00};
    dat_i <= wd;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (ack_o !== 1'b1) begin
      n_fail++;
      close_out();
    end else begin
      rd = dat_o;
      q2 = dat_o2;
      cyc_i <= 0;
      stb_i <= 0;
      we_i <= 0;
    end
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 0;
    for (int i = 0; i < 3; i++) begin
      wb(0, IDX_PHASE_A_COMP + 16'(i), '0, q);
      chk(q, '0);
    end
    for (int i = 0; i < 12; i++) begin
      r = rnd();
      d = (i < 8) ? {r[31:10], corner[i]} : r;
      wb(1, IDX_PHASE_A_COMP + 16'(i % 3), d, q);
      wb(0, IDX_PHASE_A_COMP + 16'(i % 3), '0, q);
      chk(q, {22'h0, d[9:0]});
      chk({22'h0, eff[i % 3]}, {22'h0, alias_of(d[9:0])});
    end
    wb(0, 16'h0001, '0, q);
    chk(q, '0);
    msk = 9'(rnd()) | 9'h001;
    wb(1, IDX_IRQ_MASK, {23'h0, msk}, q);
    prev_s = '0;
    ist = '0;
    for (int i = 0; i < 16; i++) begin
      r = rnd();
      sc = r[1:0];
      cfg = {r[17:15], 3'((i + 3) % 8), 3'(i % 8), r[8:0]};
      wb(1, IDX_SIGN_CTRL, {30'h0, sc}, q);
      wb(1, IDX_PULSE_CFG, {14'h0, cfg}, q);
      @(posedge clk_i);
      for (int k = 0; k < 5; k++) begin
        w = {rnd(), rnd(), rnd()};
        pw[k] <= w[71:0];
      end
      rv <= 1;
      @(posedge clk_i);
      rv <= 0;
      exp_s = exp_sign(sc, cfg);
      ist |= exp_s[8:0] ^ prev_s[8:0];
      prev_s = exp_s;
      wb(1, IDX_POWER_SIGN, 32'h0000ffff, q);
      wb(0, IDX_POWER_SIGN, '0, q);
      chk(q, {16'h0, exp_s});
      chk({16'h0, q[15:9], 9'h000}, '0);
      chk(q2, {16'h0, exp_s & 16'hff8f});
      chk({29'h0, pen}, {29'h0, cfg[17:15] < 3'h5, cfg[14:12] < 3'h5,
        cfg[11:9] < 3'h5});
      chk({31'h0, irq_o}, {31'h0, |(ist & msk)});
      if (i % 4 == 3) begin
        wb(1, IDX_IRQ_STATUS, 32'h000001ff, q);
        ist = '0;
        chk({31'h0, irq_o}, '0);
      end
    end
    close_out();
  end
endmodule
`default_nettype wire
